// ### inc/apim_pkg.sv
/*
 * Shared constants for the alarm polarity and interrupt masking block:
 * register offsets, field positions, reset values and the polarity helper.
 * Assumes an 8-bit register port with 8-bit addresses.
 */
package apim_pkg;

    // Register port geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_POLARITY   = 8'h16;
    localparam logic [ADDR_W-1:0] OFS_ABS_MASK   = 8'h17;
    localparam logic [ADDR_W-1:0] OFS_OFSLK_MASK = 8'h18;

    // Reset values, reserved upper bits included (upper nibble for polarity, upper five bits for the masks)
    localparam logic [DATA_W-1:0] RST_POLARITY   = 8'hdf;
    localparam logic [DATA_W-1:0] RST_ABS_MASK   = 8'h3f;
    localparam logic [DATA_W-1:0] RST_OFSLK_MASK = 8'h3f;

    // Writable field widths
    localparam int unsigned POL_W  = 4;
    localparam int unsigned MASK_W = 3;

    // Polarity register fields
    localparam int unsigned BIT_ACTIVE_POL = 3;
    localparam int unsigned BIT_BAD_POL    = 2;
    localparam int unsigned BIT_UNLOCK_POL = 1;
    localparam int unsigned BIT_IRQ_POL    = 0;

    // Signal-absent mask fields
    localparam int unsigned BIT_IN2_ABS  = 2;
    localparam int unsigned BIT_IN1_ABS  = 1;
    localparam int unsigned BIT_XTAL_ABS = 0;

    // Offset and lock mask fields
    localparam int unsigned BIT_IN2_FOFS = 2;
    localparam int unsigned BIT_IN1_FOFS = 1;
    localparam int unsigned BIT_UNLOCK   = 0;

    // Number of alarm flags feeding the interrupt
    localparam int unsigned NUM_FLAGS = 6;

    // Pin level for a status under a polarity bit (1 = active high)
    function automatic logic apply_pol(input logic status,
                                       input logic active_high);
        return active_high ? status : ~status;
    endfunction

endpackage

// ### logic/apim_pin_drive.sv
/*
 * Registered output stage for one alarm pin: applies polarity and enable.
 * Assumes status and enable come from logic on core_clk.
 */
`timescale 1ns/1ps
module apim_pin_drive (
    // Clock, reset, enable
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic ce,
    // Source
    input  wire logic status,
    input  wire logic active_high,
    input  wire logic enable,
    // Pin
    output logic      pin_o,
    output logic      pin_oe
);

    // Level with polarity applied
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_o <= 1'b0;
        end else if (ce) begin
            pin_o <= apim_pkg::apply_pol(status, active_high);
        end
    end

    // Tristate when disabled
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_oe <= 1'b0;
        end else if (ce) begin
            pin_oe <= enable;
        end
    end

endmodule // apim_pin_drive

// ### logic/apim_irq_combine.sv
/*
 * Combines latched alarm flags under their masks into one status.
 * Assumes flags are held elsewhere; this stage never alters them.
 */
`timescale 1ns/1ps
module apim_irq_combine #(
    parameter int unsigned N = 6
) (
    // Flags and masks
    input  wire logic [N-1:0] flags,
    input  wire logic [N-1:0] mask,
    // Result
    output logic              irq_status
);

    if (N < 1) begin : g_bad_count
        $error("apim_irq_combine: N must be at least 1");
    end

    // OR of unmasked flags
    assign irq_status = |(flags & ~mask);

endmodule // apim_irq_combine

// ### logic/apim_alarm_ctrl.sv
/*
 * Alarm output conditioning: polarity and interrupt mask registers,
 * interrupt combine, and the four alarm output pins.
 * Assumes flags, status bits and output enables come from core_clk logic;
 * the register port is a simple synchronous write/read strobe interface.
 */
`timescale 1ns/1ps

module apim_alarm_ctrl (
    // Clock, reset, enable
    input  wire logic                          core_clk,
    input  wire logic                          nrst,
    input  wire logic                          ce,
    // Register port
    input  wire logic                          reg_wr_en,
    input  wire logic                          reg_rd_en,
    input  wire logic [apim_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [apim_pkg::DATA_W-1:0]   reg_wdata,
    output logic      [apim_pkg::DATA_W-1:0]   reg_rdata,
    output logic                               reg_rvalid,
    // Latched alarm flags
    input  wire logic                          input2_absent_flag,
    input  wire logic                          input1_absent_flag,
    input  wire logic                          xtal_absent_flag,
    input  wire logic                          input2_freq_offset_flag,
    input  wire logic                          input1_freq_offset_flag,
    input  wire logic                          unlock_flag,
    // Status levels
    input  wire logic                          clock_active_status,
    input  wire logic                          input1_bad_status,
    input  wire logic                          input2_bad_status,
    input  wire logic                          unlock_status,
    // Output enables
    input  wire logic                          clock_active_output_enable,
    input  wire logic                          input1_bad_output_enable,
    input  wire logic                          input2_bad_output_enable,
    input  wire logic                          unlock_output_enable,
    input  wire logic                          irq_output_enable,
    // Pins
    output logic                               select_or_active_pin_o,
    output logic                               select_or_active_pin_oe,
    output logic                               irq_or_input1_bad_pin_o,
    output logic                               irq_or_input1_bad_pin_oe,
    output logic                               input2_bad_pin_o,
    output logic                               input2_bad_pin_oe,
    output logic                               unlock_pin_o,
    output logic                               unlock_pin_oe,
    // Combined interrupt status, before polarity
    output logic                               irq_status
);

    logic [apim_pkg::POL_W-1:0]  polarity;
    logic [apim_pkg::MASK_W-1:0] absent_mask;
    logic [apim_pkg::MASK_W-1:0] ofslk_mask;
    logic [apim_pkg::NUM_FLAGS-1:0] flags;
    logic [apim_pkg::NUM_FLAGS-1:0] masks;
    logic                        irq_raw;
    logic                        shared_status;
    logic                        shared_active_high;
    logic                        shared_enable;
    logic [apim_pkg::DATA_W-1:0] next_rdata;

    // Polarity register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            polarity <= apim_pkg::RST_POLARITY[apim_pkg::POL_W-1:0];
        end else if (ce && reg_wr_en
                     && reg_addr == apim_pkg::OFS_POLARITY) begin
            polarity <= reg_wdata[apim_pkg::POL_W-1:0];
        end
    end

    // Signal-absent mask register; flags are held outside
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            absent_mask <= apim_pkg::RST_ABS_MASK[apim_pkg::MASK_W-1:0];
        end else if (ce && reg_wr_en
                     && reg_addr == apim_pkg::OFS_ABS_MASK) begin
            absent_mask <= reg_wdata[apim_pkg::MASK_W-1:0];
        end
    end

    // Offset and lock mask register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ofslk_mask <= apim_pkg::RST_OFSLK_MASK[apim_pkg::MASK_W-1:0];
        end else if (ce && reg_wr_en
                     && reg_addr == apim_pkg::OFS_OFSLK_MASK) begin
            ofslk_mask <= reg_wdata[apim_pkg::MASK_W-1:0];
        end
    end

    // Read mux; reserved bits read as their reset pattern
    always_comb begin
        case (reg_addr)
            apim_pkg::OFS_POLARITY: begin
                next_rdata = {apim_pkg::RST_POLARITY[7:apim_pkg::POL_W],
                              polarity};
            end
            apim_pkg::OFS_ABS_MASK: begin
                next_rdata = {apim_pkg::RST_ABS_MASK[7:apim_pkg::MASK_W],
                              absent_mask};
            end
            apim_pkg::OFS_OFSLK_MASK: begin
                next_rdata = {apim_pkg::RST_OFSLK_MASK[7:apim_pkg::MASK_W],
                              ofslk_mask};
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (ce && reg_rd_en) begin
            reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= reg_rd_en;
        end
    end

    // Flag and mask vectors, same bit order
    assign flags = {input2_freq_offset_flag, input1_freq_offset_flag,
                    unlock_flag, input2_absent_flag, input1_absent_flag,
                    xtal_absent_flag};
    assign masks = {ofslk_mask[apim_pkg::BIT_IN2_FOFS],
                    ofslk_mask[apim_pkg::BIT_IN1_FOFS],
                    ofslk_mask[apim_pkg::BIT_UNLOCK],
                    absent_mask[apim_pkg::BIT_IN2_ABS],
                    absent_mask[apim_pkg::BIT_IN1_ABS],
                    absent_mask[apim_pkg::BIT_XTAL_ABS]};

    apim_irq_combine #(
        .N          (apim_pkg::NUM_FLAGS)
    ) u_combine (
        .flags      (flags),
        .mask       (masks),
        .irq_status (irq_raw)
    );

    // Raw status registered for software visibility
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq_status <= 1'b0;
        end else if (ce) begin
            irq_status <= irq_raw;
        end
    end

    // Shared pin source selection
    always_comb begin
        if (irq_output_enable) begin
            shared_status      = irq_raw;
            shared_active_high = polarity[apim_pkg::BIT_IRQ_POL];
            shared_enable      = 1'b1;
        end else begin
            shared_status      = input1_bad_status;
            shared_active_high = polarity[apim_pkg::BIT_BAD_POL];
            shared_enable      = input1_bad_output_enable;
        end
    end

    apim_pin_drive u_active_pin (
        .core_clk    (core_clk),
        .nrst        (nrst),
        .ce          (ce),
        .status      (clock_active_status),
        .active_high (polarity[apim_pkg::BIT_ACTIVE_POL]),
        .enable      (clock_active_output_enable),
        .pin_o       (select_or_active_pin_o),
        .pin_oe      (select_or_active_pin_oe)
    );

    apim_pin_drive u_shared_pin (
        .core_clk    (core_clk),
        .nrst        (nrst),
        .ce          (ce),
        .status      (shared_status),
        .active_high (shared_active_high),
        .enable      (shared_enable),
        .pin_o       (irq_or_input1_bad_pin_o),
        .pin_oe      (irq_or_input1_bad_pin_oe)
    );

    apim_pin_drive u_input2_pin (
        .core_clk    (core_clk),
        .nrst        (nrst),
        .ce          (ce),
        .status      (input2_bad_status),
        .active_high (polarity[apim_pkg::BIT_BAD_POL]),
        .enable      (input2_bad_output_enable),
        .pin_o       (input2_bad_pin_o),
        .pin_oe      (input2_bad_pin_oe)
    );

    apim_pin_drive u_unlock_pin (
        .core_clk    (core_clk),
        .nrst        (nrst),
        .ce          (ce),
        .status      (unlock_status),
        .active_high (polarity[apim_pkg::BIT_UNLOCK_POL]),
        .enable      (unlock_output_enable),
        .pin_o       (unlock_pin_o),
        .pin_oe      (unlock_pin_oe)
    );

    // Helper: registers not yet written since reset
    logic pol_written;
    logic ofslk_written;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pol_written   <= 1'b0;
            ofslk_written <= 1'b0;
        end else if (ce && reg_wr_en) begin
            if (reg_addr == apim_pkg::OFS_POLARITY) begin
                pol_written <= 1'b1;
            end
            if (reg_addr == apim_pkg::OFS_OFSLK_MASK) begin
                ofslk_written <= 1'b1;
            end
        end
    end

    // Reads of the polarity and offset/lock mask registers after reset
    sequence s_pol_read;
        ce && reg_rd_en && reg_addr == apim_pkg::OFS_POLARITY
           && !pol_written && !reg_wr_en;
    endsequence

    sequence s_ofslk_read;
        ce && reg_rd_en && reg_addr == apim_pkg::OFS_OFSLK_MASK
           && !ofslk_written && !reg_wr_en;
    endsequence

    a_active_pin_level: assert property (
        @(posedge core_clk) disable iff (!nrst)
        ce |=> select_or_active_pin_o
               == ($past(polarity[apim_pkg::BIT_ACTIVE_POL])
                   ? $past(clock_active_status) : !$past(clock_active_status)))
        else $error("clock active pin level wrong");
    a_input2_pin_level: assert property (
        @(posedge core_clk) disable iff (!nrst)
        ce |=> input2_bad_pin_o
               == ($past(polarity[apim_pkg::BIT_BAD_POL])
                   ? $past(input2_bad_status) : !$past(input2_bad_status)))
        else $error("input 2 bad pin level wrong");
    a_unlock_pin_level: assert property (
        @(posedge core_clk) disable iff (!nrst)
        ce |=> unlock_pin_o
               == ($past(polarity[apim_pkg::BIT_UNLOCK_POL])
                   ? $past(unlock_status) : !$past(unlock_status)))
        else $error("unlock pin level wrong");
    a_irq_pin_level: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (ce && irq_output_enable) |=> irq_or_input1_bad_pin_oe
            && irq_or_input1_bad_pin_o
               == ($past(polarity[apim_pkg::BIT_IRQ_POL])
                   ? $past(irq_raw) : !$past(irq_raw)))
        else $error("interrupt pin level wrong");
    a_in2_abs_mask: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (flags == 6'h04) |-> irq_raw == !absent_mask[apim_pkg::BIT_IN2_ABS])
        else $error("input 2 absent mask wrong");
    a_in1_abs_mask: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (flags == 6'h02) |-> irq_raw == !absent_mask[apim_pkg::BIT_IN1_ABS])
        else $error("input 1 absent mask wrong");
    a_xtal_abs_mask: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (flags == 6'h01) |-> irq_raw == !absent_mask[apim_pkg::BIT_XTAL_ABS])
        else $error("crystal absent mask wrong");
    a_in2_fofs_mask: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (flags == 6'h20) |-> irq_raw == !ofslk_mask[apim_pkg::BIT_IN2_FOFS])
        else $error("input 2 offset mask wrong");
    a_in1_fofs_mask: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (flags == 6'h10) |-> irq_raw == !ofslk_mask[apim_pkg::BIT_IN1_FOFS])
        else $error("input 1 offset mask wrong");
    a_unlock_mask: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (flags == 6'h08) |-> irq_raw == !ofslk_mask[apim_pkg::BIT_UNLOCK])
        else $error("unlock mask wrong");
    a_pol_reset_value: assert property (
        @(posedge core_clk) disable iff (!nrst)
        s_pol_read |=> reg_rvalid && reg_rdata == apim_pkg::RST_POLARITY)
        else $error("polarity reset value wrong");
    a_ofslk_reset_value: assert property (
        @(posedge core_clk) disable iff (!nrst)
        s_ofslk_read |=> reg_rvalid && reg_rdata == apim_pkg::RST_OFSLK_MASK)
        else $error("offset and lock mask reset value wrong");
    a_shared_pin_enable: assert property (
        @(posedge core_clk) disable iff (!nrst)
        ce |=> irq_or_input1_bad_pin_oe
               == ($past(irq_output_enable) || $past(input1_bad_output_enable)))
        else $error("shared pin enable wrong");
    a_unlock_pin_enable: assert property (
        @(posedge core_clk) disable iff (!nrst)
        ce |=> unlock_pin_oe == $past(unlock_output_enable))
        else $error("unlock pin enable wrong");
    a_input2_pin_enable: assert property (
        @(posedge core_clk) disable iff (!nrst)
        ce |=> input2_bad_pin_oe == $past(input2_bad_output_enable))
        else $error("input 2 pin enable wrong");
    a_irq_combine_or: assert property (
        @(posedge core_clk) disable iff (!nrst)
        ce |=> irq_status == $past(|(flags & ~masks)))
        else $error("interrupt combine wrong");

endmodule // apim_alarm_ctrl

// ### tb/apim_board_monitor.sv
/*
 * Board-side watcher of the four alarm pins: resolves each pin's level.
 * Assumes pin order {clock-active, irq/input1-bad, input2-bad, unlock}.
 */
`timescale 1ns/1ps
module apim_board_monitor (
    // Clock
    input  wire logic       core_clk,
    // Pins from the device
    input  wire logic [3:0] pin_o,
    input  wire logic [3:0] pin_oe,
    // Resolved board levels
    output logic      [3:0] line
);
    logic [3:0] last;

    // Released pin shows inverse of last driven level, never a stale copy
    always @(posedge core_clk) begin
        last <= (pin_o & pin_oe) | (last & ~pin_oe);
    end
    assign line = (pin_o & pin_oe) | (~last & ~pin_oe);
endmodule // apim_board_monitor

// ### tb/tb_alarm_polarity_and_irq_masking.sv
/*
 * Self-checking bench: register port, interrupt masking and pin polarity.
 * Assumes the hand-over timing: reads answer one cycle after the strobe.
 */
`timescale 1ns/1ps
module tb_alarm_polarity_and_irq_masking;
    logic       core_clk, nrst, ce, reg_wr_en, reg_rd_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, pol, absm, ofsm;
    logic       reg_rvalid, irq_status;
    logic [5:0] flg;
    logic [3:0] st, pin_o, pin_oe, line;
    logic [4:0] en;
    int         errors, cmp_count, cycles;

    apim_alarm_ctrl u_dut (
        .core_clk(core_clk), .nrst(nrst), .ce(ce),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .input2_absent_flag(flg[5]), .input1_absent_flag(flg[4]),
        .xtal_absent_flag(flg[3]), .input2_freq_offset_flag(flg[2]),
        .input1_freq_offset_flag(flg[1]), .unlock_flag(flg[0]),
        .clock_active_status(st[3]), .input1_bad_status(st[2]),
        .input2_bad_status(st[1]), .unlock_status(st[0]),
        .clock_active_output_enable(en[4]),
        .input1_bad_output_enable(en[3]),
        .input2_bad_output_enable(en[2]),
        .unlock_output_enable(en[1]), .irq_output_enable(en[0]),
        .select_or_active_pin_o(pin_o[3]),
        .select_or_active_pin_oe(pin_oe[3]),
        .irq_or_input1_bad_pin_o(pin_o[2]),
        .irq_or_input1_bad_pin_oe(pin_oe[2]),
        .input2_bad_pin_o(pin_o[1]), .input2_bad_pin_oe(pin_oe[1]),
        .unlock_pin_o(pin_o[0]), .unlock_pin_oe(pin_oe[0]),
        .irq_status(irq_status)
    );

    apim_board_monitor u_board (
        .core_clk(core_clk), .pin_o(pin_o), .pin_oe(pin_oe), .line(line)
    );

    always #2.5 core_clk = ~core_clk;

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            conclude();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time,
                     got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr_en <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd_en <= 1'b1;
        reg_addr  <= a;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        #1;
        chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, exp);
    endtask

    // Expected interrupt: OR of unmasked flags
    function automatic logic exp_irq();
        return |(flg & ~{absm[2:0], ofsm[2:0]});
    endfunction

    // Expected {oe, level} of the four pins
    function automatic logic [7:0] exp_pins();
        logic [3:0] o, oe;
        o[3]  = st[3] ^ ~pol[3];
        o[2]  = en[0] ? exp_irq() ^ ~pol[0] : st[2] ^ ~pol[2];
        o[1]  = st[1] ^ ~pol[2];
        o[0]  = st[0] ^ ~pol[1];
        oe    = {en[4], en[0] | en[3], en[2], en[1]};
        return {oe, o & oe};
    endfunction

    task automatic settle_check();
        repeat (3) @(posedge core_clk);
        #1;
        chk({7'h00, irq_status}, {7'h00, exp_irq()});
        chk({pin_oe, line & pin_oe}, exp_pins());
    endtask

    initial begin
        core_clk = 1'b0; nrst = 1'b0; ce = 1'b1; reg_wr_en = 1'b0;
        reg_rd_en = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
        flg = 6'h00; st = 4'h0; en = 5'h00;
        errors = 0; cmp_count = 0; cycles = 0;
        pol = apim_pkg::RST_POLARITY;
        absm = apim_pkg::RST_ABS_MASK;
        ofsm = apim_pkg::RST_OFSLK_MASK;
        void'($urandom(32'h5381c64e));
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        reg_read(apim_pkg::OFS_POLARITY, 8'hdf);
        reg_read(apim_pkg::OFS_ABS_MASK, 8'h3f);
        reg_read(apim_pkg::OFS_OFSLK_MASK, 8'h3f);
        reg_read(8'h19, 8'h00);
        // All flags up under reset masks, all pins enabled
        @(posedge core_clk);
        flg <= 6'h3f;
        en  <= 5'h1f;
        st  <= 4'hf;
        settle_check();
        reg_write(apim_pkg::OFS_ABS_MASK, 8'h00);
        absm = 8'h38;
        reg_write(apim_pkg::OFS_OFSLK_MASK, 8'h00);
        ofsm = 8'h38;
        // Each flag alone, then masked while the flag stays up
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            flg <= 6'h01 << i;
            settle_check();
            if (i >= 3) begin
                absm = 8'h38 | (8'h01 << (i - 3));
                reg_write(apim_pkg::OFS_ABS_MASK, absm);
            end else begin
                ofsm = 8'h38 | (8'h01 << i);
                reg_write(apim_pkg::OFS_OFSLK_MASK, ofsm);
            end
            settle_check();
            absm = 8'h38;
            ofsm = 8'h38;
            reg_write(apim_pkg::OFS_ABS_MASK, 8'h00);
            reg_write(apim_pkg::OFS_OFSLK_MASK, 8'h00);
        end
        // Write while clock enable is low is dropped
        @(posedge core_clk);
        ce <= 1'b0;
        reg_write(apim_pkg::OFS_POLARITY, 8'h00);
        @(posedge core_clk);
        ce <= 1'b1;
        reg_read(apim_pkg::OFS_POLARITY, 8'hdf);
        // Random polarity, masks, flags, status and enables
        for (int n = 0; n < 150; n++) begin
            pol  = 8'hd0 | ($urandom() & 8'h0f);
            absm = 8'h38 | ($urandom() & 8'h07);
            ofsm = 8'h38 | ($urandom() & 8'h07);
            reg_write(apim_pkg::OFS_POLARITY, pol ^ ($urandom() & 8'hf0));
            reg_write(apim_pkg::OFS_ABS_MASK, absm ^ ($urandom() & 8'hf8));
            reg_write(apim_pkg::OFS_OFSLK_MASK, ofsm ^ ($urandom() & 8'hf8));
            @(posedge core_clk);
            flg <= 6'($urandom());
            st  <= 4'($urandom());
            en  <= 5'($urandom());
            settle_check();
            reg_read(apim_pkg::OFS_POLARITY, pol);
            reg_read(apim_pkg::OFS_ABS_MASK, absm);
            reg_read(apim_pkg::OFS_OFSLK_MASK, ofsm);
        end
        // Mid-run reset restores defaults and releases the pins
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk({4'h0, pin_oe}, 8'h00);
        nrst <= 1'b1;
        reg_read(apim_pkg::OFS_POLARITY, 8'hdf);
        reg_read(apim_pkg::OFS_OFSLK_MASK, 8'h3f);
        conclude();
    end
endmodule // tb_alarm_polarity_and_irq_masking
